// ### inc/wdt_defines.vh
`ifndef WDT_DEFINES_VH
`define WDT_DEFINES_VH

// register indexes, byte address is four times the index
`define WDT_IDX_CONFIG      16'h0000
`define WDT_IDX_STATUS      16'h0001
`define WDT_IDX_MASK        16'h0002
`define WDT_IDX_COUNT       16'h0003
`define WDT_IDX_SERVICE     16'hffff

// configuration fields
`define WDT_CFG_DISABLE     0
`define WDT_CFG_RATE        1
`define WDT_CFG_PIN_EN      2
`define WDT_CFG_BRK_DIS     3
`define WDT_CFG_WIDTH       4
`define WDT_CFG_RESET       4'h0

// status and mask fields
`define WDT_ST_CAUSE        0
`define WDT_ST_POR_DONE     1
`define WDT_ST_WIDTH        2
`define WDT_ST_RESET        2'h0
`define WDT_MASK_RESET      2'h0

// timing in fourfold oscillator cycles
`define WDT_LONG_CYCLES     18'd262128
`define WDT_SHORT_CYCLES    18'd8176
`define WDT_PIN_CYCLES      6'd32
`define WDT_POR_CYCLES      13'd4096

// counter widths
`define WDT_PRESC_WIDTH     12
`define WDT_CNT_WIDTH       6
`define WDT_PRESC_LOW_KEEP  4

// ahb
`define WDT_HTRANS_NONSEQ   2'h2
`define WDT_HRESP_OKAY      1'b0

`endif

// ### verilog/wdt_prescaler.v
`timescale 1ns/1ns
`include "wdt_defines.vh"

module wdt_prescaler #(
   parameter WIDTH = `WDT_PRESC_WIDTH,
   parameter KEEP  = `WDT_PRESC_LOW_KEEP
) (
   input  wire             clk,
   input  wire             rst_n,
   input  wire             tick,
   input  wire             clr_all,
   input  wire             clr_upper,
   output wire [WIDTH-1:0] value,
   output wire             carry
);

   reg  [WIDTH-1:0] presc_reg;
   reg  [WIDTH-1:0] presc_next;
   wire [KEEP-1:0]  low_inc;

   assign low_inc = presc_reg[KEEP-1:0] + {{(KEEP-1){1'b0}}, tick};

   // carry out of the top stage clocks the watchdog counter
   assign carry = tick & (&presc_reg);
   assign value = presc_reg;

   always @* begin
      presc_next = presc_reg;
      if (clr_all) begin
         presc_next = {WIDTH{1'b0}};
      end else if (clr_upper) begin
         // upper stages cleared, low stages keep running
         presc_next = {{(WIDTH-KEEP){1'b0}}, low_inc};
      end else if (tick) begin
         presc_next = presc_reg + {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         presc_reg <= {WIDTH{1'b0}};
      end else begin
         presc_reg <= presc_next;
      end
   end

endmodule

// ### verilog/wdt_top.v
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/1ns
`include "wdt_defines.vh"


module wdt_top #(
   parameter        TICK_DIV     = 1,
   parameter [17:0] LONG_CYCLES  = `WDT_LONG_CYCLES,
   parameter [17:0] SHORT_CYCLES = `WDT_SHORT_CYCLES
) (
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        hsel,
   input  wire [17:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output wire        hreadyout,
   output wire        hresp,
   output wire [31:0] hrdata,
   input  wire [7:0]  reset_vector_low,
   input  wire        internal_reset,
   input  wire        stop_enter,
   input  wire        stop_mode,
   input  wire        wait_mode,
   input  wire        high_test_voltage_pin,
   input  wire        break_active,
   output wire        watchdog_reset,
   output wire        rst_pin_o,
   output wire        rst_pin_oe,
   output wire        irq
);

   localparam ST_RUN  = 1'b0;
   localparam ST_HOLD = 1'b1;

   localparam [17:0] LONG_LAST  = LONG_CYCLES - 18'd1;
   localparam [17:0] SHORT_LAST = SHORT_CYCLES - 18'd1;
   localparam [5:0]  PIN_LAST   = `WDT_PIN_CYCLES - 6'd1;
   localparam [12:0] POR_LAST   = `WDT_POR_CYCLES - 13'd1;
   localparam [15:0] DIV_LAST   = TICK_DIV[15:0] - 16'd1;

   function [15:0] wdt_index;
      input [17:0] addr;
      begin
         wdt_index = addr[17:2];
      end
   endfunction

   // ------------------------------------------------------------
   // pin synchroniser
   reg         mon_s1_reg;
   reg         mon_s2_reg;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mon_s1_reg <= 1'b0;
         mon_s2_reg <= 1'b0;
      end else begin
         mon_s1_reg <= high_test_voltage_pin;
         mon_s2_reg <= mon_s1_reg;
      end
   end

   // ------------------------------------------------------------
   // fourfold oscillator tick, removed while stopped
   reg  [15:0] div_cnt_reg;
   wire        div_hit;
   wire        tick;

   assign div_hit = (div_cnt_reg == DIV_LAST);
   assign tick    = div_hit & ~stop_mode;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_cnt_reg <= 16'h0000;
      end else if (div_hit) begin
         div_cnt_reg <= 16'h0000;
      end else begin
         div_cnt_reg <= div_cnt_reg + 16'h0001;
      end
   end

   // ------------------------------------------------------------
   // power-on delay
   reg  [12:0] por_cnt_reg;
   reg         por_done_reg;
   wire        por_end;

   assign por_end = ~por_done_reg & tick & (por_cnt_reg == POR_LAST);

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         por_cnt_reg  <= 13'h0000;
         por_done_reg <= 1'b0;
      end else if (por_end) begin
         por_done_reg <= 1'b1;
      end else if (~por_done_reg & tick) begin
         por_cnt_reg <= por_cnt_reg + 13'h0001;
      end
   end

   // ------------------------------------------------------------
   // bus slave
   reg         wr_pend_reg;
   reg  [15:0] wr_idx_reg;
   reg  [31:0] hrdata_reg;
   reg  [31:0] rd_next;
   wire        ap_valid;
   wire [15:0] ap_idx;
   wire        wr_service;
   wire        wr_config;
   wire        wr_status;
   wire        wr_mask;

   assign ap_valid   = hsel & htrans[1] & hready;
   assign ap_idx     = wdt_index(haddr);
   assign hreadyout  = 1'b1;
   assign hresp      = `WDT_HRESP_OKAY;
   assign hrdata     = hrdata_reg;

   // any data value services the watchdog, reads never do
   assign wr_service = wr_pend_reg & (wr_idx_reg == `WDT_IDX_SERVICE);
   assign wr_config  = wr_pend_reg & (wr_idx_reg == `WDT_IDX_CONFIG);
   assign wr_status  = wr_pend_reg & (wr_idx_reg == `WDT_IDX_STATUS);
   assign wr_mask    = wr_pend_reg & (wr_idx_reg == `WDT_IDX_MASK);

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_idx_reg  <= 16'h0000;
      end else begin
         wr_pend_reg <= ap_valid & hwrite;
         if (ap_valid) begin
            wr_idx_reg <= ap_idx;
         end
      end
   end

   // ------------------------------------------------------------
   // configuration, writable once after each reset
   reg  [3:0]  cfg_reg;
   reg         cfg_locked_reg;
   reg  [1:0]  status_reg;
   reg  [1:0]  mask_reg;
   reg         state_reg;
   reg  [5:0]  hold_cnt_reg;
   wire        sys_reset;
   wire        cfg_disable;
   wire        cfg_rate;
   wire        cfg_pin_en;
   wire        cfg_brk_dis;

   assign sys_reset   = internal_reset | (state_reg == ST_HOLD);
   assign cfg_disable = cfg_reg[`WDT_CFG_DISABLE];
   assign cfg_rate    = cfg_reg[`WDT_CFG_RATE];
   assign cfg_pin_en  = cfg_reg[`WDT_CFG_PIN_EN];
   assign cfg_brk_dis = cfg_reg[`WDT_CFG_BRK_DIS];

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_reg        <= `WDT_CFG_RESET;
         cfg_locked_reg <= 1'b0;
      end else if (sys_reset) begin
         // pin function survives all but power-on reset
         cfg_reg        <= `WDT_CFG_RESET | (cfg_reg & 4'h4);
         cfg_locked_reg <= 1'b0;
      end else if (wr_config & ~cfg_locked_reg) begin
         cfg_reg        <= hwdata[3:0];
         cfg_locked_reg <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // prescaler and watchdog counter
   reg  [5:0]  cnt_reg;
   reg  [5:0]  cnt_next;
   wire [11:0] presc_value;
   wire        presc_carry;
   wire        inhibit;
   wire        count_en;
   wire        presc_clr;
   wire        cnt_clr;
   wire [17:0] combined;
   wire [17:0] last_value;
   wire        timeout;

   // disable bit 1 disables, monitor mode and break suspend as well
   assign inhibit = cfg_disable
                  | mon_s2_reg
                  | (break_active & cfg_brk_dis);

   // wait mode is deliberately not a term here
   assign count_en  = tick & por_done_reg & ~inhibit & (state_reg == ST_RUN);
   assign presc_clr = sys_reset
                    | stop_enter
                    | por_end;
   assign cnt_clr   = sys_reset | wr_service;

   wdt_prescaler #(
      .WIDTH (`WDT_PRESC_WIDTH),
      .KEEP  (`WDT_PRESC_LOW_KEEP)
   ) u_presc (
      .clk       (hclk),
      .rst_n     (hresetn),
      .tick      (count_en),
      .clr_all   (presc_clr),
      .clr_upper (wr_service),
      .value     (presc_value),
      .carry     (presc_carry)
   );

   always @* begin
      cnt_next = cnt_reg;
      if (cnt_clr) begin
         cnt_next = 6'h00;
      end else if (presc_carry) begin
         cnt_next = cnt_reg + 6'h01;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_reg <= 6'h00;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   assign combined   = {cnt_reg, presc_value};
   assign last_value = cfg_rate ? SHORT_LAST : LONG_LAST;
   assign timeout    = count_en & ~cnt_clr & ~presc_clr & (combined == last_value);

   // ------------------------------------------------------------
   // reset hold sequence
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg    <= ST_RUN;
         hold_cnt_reg <= 6'h00;
      end else begin
         case (state_reg)
            ST_RUN: begin
               hold_cnt_reg <= 6'h00;
               if (timeout) begin
                  state_reg <= ST_HOLD;
               end
            end
            ST_HOLD: begin
               if (tick) begin
                  if (hold_cnt_reg == PIN_LAST) begin
                     state_reg    <= ST_RUN;
                     hold_cnt_reg <= 6'h00;
                  end else begin
                     hold_cnt_reg <= hold_cnt_reg + 6'h01;
                  end
               end
            end
            default: begin
               state_reg    <= ST_RUN;
               hold_cnt_reg <= 6'h00;
            end
         endcase
      end
   end

   // reset is the only action toward the processor
   assign watchdog_reset = (state_reg == ST_HOLD);
   assign rst_pin_o      = 1'b0;
   assign rst_pin_oe     = (state_reg == ST_HOLD) & cfg_pin_en;

   // ------------------------------------------------------------
   // reset cause and system status
   reg  [1:0]  status_set;

   always @* begin
      status_set = 2'b00;
      status_set[`WDT_ST_CAUSE]    = timeout;
      status_set[`WDT_ST_POR_DONE] = por_end;
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status_reg <= `WDT_ST_RESET;
         mask_reg   <= `WDT_MASK_RESET;
      end else begin
         // set wins over a simultaneous clear
         if (wr_status) begin
            status_reg <= (status_reg & ~hwdata[1:0]) | status_set;
         end else begin
            status_reg <= status_reg | status_set;
         end
         if (wr_mask) begin
            mask_reg <= hwdata[1:0];
         end
      end
   end

   // system status line, not a processor interrupt request
   assign irq = |(status_reg & mask_reg);

   // ------------------------------------------------------------
   // read data
   always @* begin
      rd_next = 32'h0000_0000;
      case (ap_idx)
         `WDT_IDX_CONFIG:  rd_next = {27'h0, cfg_locked_reg, cfg_reg};
         `WDT_IDX_STATUS:  rd_next = {30'h0, status_reg};
         `WDT_IDX_MASK:    rd_next = {30'h0, mask_reg};
         `WDT_IDX_COUNT:   rd_next = {14'h0, combined};
         `WDT_IDX_SERVICE: rd_next = {24'h0, reset_vector_low};
         default:          rd_next = 32'h0000_0000;
      endcase
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_reg <= 32'h0000_0000;
      end else if (ap_valid & ~hwrite) begin
         hrdata_reg <= rd_next;
      end
   end

endmodule

// ### bench/wdt_checker.sv
`timescale 1ns/1ns
module wdt_checker (
   input wire        hclk,
   input wire        hresetn,
   input wire        hsel,
   input wire [17:0] haddr,
   input wire [1:0]  htrans,
   input wire        hwrite,
   input wire        hready,
   input wire        hreadyout,
   input wire        hresp,
   input wire [31:0] hrdata,
   input wire [7:0]  reset_vector_low,
   input wire        high_test_voltage_pin,
   input wire        watchdog_reset,
   input wire        rst_pin_o,
   input wire        rst_pin_oe
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic [5:0] hi_reg;
   wire        rd = hsel & htrans[1] & hready & !hwrite;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) hi_reg <= 6'h00;
      else hi_reg <= watchdog_reset ? hi_reg + 6'h01 : 6'h00;
   end
   a_pulse_len: assert property ($fell(watchdog_reset) |-> hi_reg == 6'h20)
      else $error("reset pulse length wrong");
   a_pin_drive: assert property (rst_pin_oe |-> watchdog_reset)
      else $error("pin driven outside reset");
   a_pin_level: assert property (rst_pin_o == 1'b0)
      else $error("pin not driven low");
   a_bus_okay: assert property (hreadyout && hresp == 1'b0)
      else $error("bus answer not ready okay");
   a_vector_read: assert property (rd && haddr[17:2] == 16'hffff
      |=> hrdata[7:0] == $past(reset_vector_low)) else $error("vector byte wrong");
   a_unmapped_read: assert property (rd && haddr[17:2] == 16'h0010 |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   a_data_hold: assert property (!rd |=> $stable(hrdata))
      else $error("read data changed");
   a_monitor_off: assert property (high_test_voltage_pin [*4] |-> !$rose(watchdog_reset))
      else $error("reset in monitor mode");
   c_timeout: cover property ($rose(watchdog_reset));
   c_pin: cover property (rst_pin_oe);
   c_vector: cover property (rd && haddr[17:2] == 16'hffff);
endmodule

// ### bench/wdt_sys_model.sv
`timescale 1ns/1ns
module wdt_sys_model (
   input wire    hclk,
   input wire    hresetn,
   input wire    reset_req,
   input wire    rst_pin_o,
   input wire    rst_pin_oe,
   output logic  internal_reset,
   output wire   rst_pin_level
);
   // pin has a pull-up when released
   assign rst_pin_level = rst_pin_oe ? rst_pin_o : 1'b1;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) internal_reset <= 1'b0;
      else internal_reset <= reset_req;
   end
endmodule

// ### bench/wdt_top_tb.sv
`timescale 1ns/1ns
module wdt_top_tb;
   localparam int SHORT = 100;
   localparam int LONG  = 300;
   localparam [17:0] SVC = 18'h3fffc;
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, req = 0;
   logic        stp = 0, stp_m = 0, wait_m = 0, hv = 0, brk = 0;
   logic [17:0] haddr = 0;
   logic [1:0]  htrans = 0;
   logic [31:0] hwdata = 0, r;
   wire         hready, hresp, wdr, oe, po, irq, ires, pin;
   wire [31:0]  hrdata;
   int          errors = 0, comparisons = 0, n, t0, cyc = 0;
   always #20 hclk = ~hclk;
   always @(posedge hclk) cyc <= cyc + 1;
   wdt_top #(.LONG_CYCLES(18'd300), .SHORT_CYCLES(18'd100)) uut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
      .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .reset_vector_low(8'ha5),
      .internal_reset(ires), .stop_enter(stp), .stop_mode(stp_m), .wait_mode(wait_m),
      .high_test_voltage_pin(hv), .break_active(brk), .watchdog_reset(wdr),
      .rst_pin_o(po), .rst_pin_oe(oe), .irq(irq));
   wdt_sys_model sys (.hclk(hclk), .hresetn(hresetn), .reset_req(req), .rst_pin_o(po),
      .rst_pin_oe(oe), .internal_reset(ires), .rst_pin_level(pin));
   task finish_test;
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task ahb(input [17:0] a, input w, input [31:0] d);
      hsel <= 1; haddr <= a; hwrite <= w; htrans <= 2'h2;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0; hsel <= 0; hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      r = hrdata;
   endtask
   task rd(input [17:0] a, input [31:0] e);
      ahb(a, 0, 0);
      chk(r, e);
   endtask
   task idle(input int c);
      repeat (c) begin
         @(posedge hclk);
         chk(wdr, 0);
      end
   endtask
   task rise_after(input int lim);
      n = 0;
      while (wdr !== 1'b1 && n < 2000) begin
         @(posedge hclk);
         n++;
      end
      chk(cyc - t0 >= lim - 18 && cyc - t0 <= lim + 2, 1);
      chk(oe, 1);
      chk(pin, 0);
   endtask
   task sys_reset;
      req <= 1;
      @(posedge hclk);
      req <= 0;
      repeat (3) @(posedge hclk);
   endtask
   initial begin
      repeat (4) @(posedge hclk);
      hresetn <= 1;
      ahb(SVC, 1, 0);
      rd(18'h0, 0);
      rd(18'h8, 0);
      rd(18'h40, 0);
      ahb(SVC, 0, 0);
      chk({24'h0, r[7:0]}, 32'ha5);
      idle(4120);
      rd(18'h4, 32'h2);
      ahb(18'h0, 1, 32'h6);
      rd(18'h0, 32'h16);
      ahb(18'h0, 1, 32'h1);
      rd(18'h0, 32'h16);
      ahb(18'h8, 1, 32'h1);
      ahb(SVC, 1, 0);
      t0 = cyc;
      rise_after(SHORT);
      chk(irq, 1);
      repeat (40) @(posedge hclk);
      rd(18'h4, 32'h3);
      ahb(18'h4, 1, 32'h1);
      rd(18'h4, 32'h2);
      chk(irq, 0);
      repeat (6) begin
         ahb(SVC, 1, 0);
         idle(60);
      end
      ahb(SVC, 1, 0);
      t0 = cyc;
      repeat (20) ahb(SVC, 0, 0);
      // the watchdog reset cleared the rate bit, so the long period applies
      rise_after(LONG);
      // let the counter run well past 32 so that the clear below shows
      repeat (140) @(posedge hclk);
      sys_reset;
      rd(18'h0, 32'h4);
      ahb(18'hc, 0, 0);
      chk(r >> 5, 0);
      ahb(18'h0, 1, 32'h4);
      stp <= 1;
      stp_m <= 1;
      @(posedge hclk);
      stp <= 0;
      idle(400);
      stp_m <= 0;
      wait_m <= 1;
      ahb(SVC, 1, 0);
      t0 = cyc;
      rise_after(LONG);
      repeat (40) @(posedge hclk);
      hv <= 1;
      idle(400);
      hv <= 0;
      sys_reset;
      ahb(18'h0, 1, 32'hc);
      brk <= 1;
      idle(400);
      brk <= 0;
      sys_reset;
      ahb(18'h0, 1, 32'h5);
      idle(400);
      finish_test;
   end
   initial begin
      repeat (20000) @(posedge hclk);
      errors++;
      finish_test;
   end
endmodule
bind wdt_top wdt_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .hrdata(hrdata), .reset_vector_low(reset_vector_low),
   .high_test_voltage_pin(high_test_voltage_pin), .watchdog_reset(watchdog_reset),
   .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe));
